// *** verilog/cbrs_regfile.sv ***
// Base register set, flags, mode word and APB register access.
// Operation
// - Two modes, real and protected addressing.
// - Real mode addresses physical, one megabyte.
// - Protected mode maps virtual space to physical.
// - Protected mode enforces limit and privilege isolation.
// - Same registers and addressing in both modes.
// - Fifteen registers in four groups.
// - Eight 16-bit general operand registers.
// - Four registers split into independent byte halves.
// - Four 16-bit segment registers select segments.
// - Four general registers serve as base/index.
// - Addressing mode selects base and index registers.
// - Three status registers including instruction pointer.
// - Flag bits 0,2,4,6,7,11 record results.
// - Flag bits 8, 9 and 10 are control.
// - Carry set on carry or borrow.
// - Parity set on even ones in byte.
// - Single step interrupt after instruction, clears bit.
// - Direction flag sets string index step sign.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module cbrs_regfile (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        core_we,
	input  wire logic [3:0]  core_wsel,
	input  wire logic [1:0]  core_wbyte,
	input  wire logic [15:0] core_wdata,
	input  wire logic [3:0]  core_rsel,
	output logic [15:0]      core_rdata,
	input  wire logic        res_valid,
	input  wire logic [15:0] res_value,
	input  wire logic        res_byte,
	input  wire logic        res_carry,
	input  wire logic        res_aux,
	input  wire logic        res_ovf,
	input  wire logic        instr_done,
	input  wire logic        ip_adv,
	input  wire logic [3:0]  ip_len,
	input  wire logic        str_step,
	input  wire logic        str_word,
	input  wire logic        ag_req,
	input  wire logic [2:0]  ag_rm,
	input  wire logic [15:0] ag_disp,
	input  wire logic [1:0]  ag_seg,
	output logic             prot_mode,
	output logic             step_irq,
	output logic             int_enable,
	output logic             str_down,
	output logic [15:0]      ip_value,
	output logic [23:0]      phys_addr,
	output logic             addr_valid,
	output logic             addr_fault
);
	typedef struct packed {
		cbrs_pkg::cbrs_apb_st_t apb_st;
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
		logic [7:0][15:0]  gp;
		logic [3:0][15:0]  seg;
		logic [3:0][23:0]  sbase;
		logic [3:0][15:0]  slim;
		logic [15:0]       ip;
		logic [15:0]       flags;
		logic [15:0]       msw;
		logic [15:0]       core_rdata;
		logic              step_irq;
	} cbrs_state_t;

	cbrs_state_t st_reg;
	cbrs_state_t st_next;
	logic        hit;
	logic [31:0] rdat;
	logic        apb_wr;
	logic [15:0] delta;
	logic [15:0] wv;

	cbrs_agu_if agu_bus ();

	always_comb begin
		st_next = st_reg;
		st_next.step_irq = 1'b0;
		hit = 1'b0;
		rdat = 32'h0000_0000;
		wv = pwdata[15:0];
		apb_wr = 1'b0;
		delta = str_word ? cbrs_pkg::STEP_WORD : cbrs_pkg::STEP_BYTE;
		// Address decode; unaligned or unlisted addresses answer with an error.
		for (int i = 0; i < cbrs_pkg::GP_N; i++) begin
			if (paddr == cbrs_pkg::A_GP + 8'(cbrs_pkg::STRIDE * i)) begin
				hit = 1'b1;
				rdat = {16'h0000, st_reg.gp[i]};
			end
		end
		for (int i = 0; i < cbrs_pkg::SEG_N; i++) begin
			if (paddr == cbrs_pkg::A_SEG + 8'(cbrs_pkg::STRIDE * i)) begin
				hit = 1'b1;
				rdat = {16'h0000, st_reg.seg[i]};
			end
			if (paddr == cbrs_pkg::A_SBASE + 8'(cbrs_pkg::STRIDE * i)) begin
				hit = 1'b1;
				rdat = {8'h00, st_reg.sbase[i]};
			end
			if (paddr == cbrs_pkg::A_SLIM + 8'(cbrs_pkg::STRIDE * i)) begin
				hit = 1'b1;
				rdat = {16'h0000, st_reg.slim[i]};
			end
		end
		if (paddr == cbrs_pkg::A_IP) begin
			hit = 1'b1;
			rdat = {16'h0000, st_reg.ip};
		end
		if (paddr == cbrs_pkg::A_FLAGS) begin
			hit = 1'b1;
			rdat = {16'h0000, st_reg.flags};
		end
		if (paddr == cbrs_pkg::A_MSW) begin
			hit = 1'b1;
			rdat = {16'h0000, st_reg.msw};
		end
		// Read data is latched one cycle early so pready and prdata leave flops together.
		case (st_reg.apb_st)
			cbrs_pkg::CBRS_IDLE: begin
				st_next.pready = 1'b0;
				st_next.pslverr = 1'b0;
				if (psel && penable) begin
					st_next.apb_st = cbrs_pkg::CBRS_ACK;
					st_next.pready = 1'b1;
					st_next.pslverr = !hit;
					st_next.prdata = pwrite ? 32'h0000_0000 : rdat;
				end
			end
			cbrs_pkg::CBRS_ACK: begin
				st_next.apb_st = cbrs_pkg::CBRS_IDLE;
				st_next.pready = 1'b0;
				st_next.pslverr = 1'b0;
				apb_wr = psel && penable && pwrite && hit;
			end
			default: begin
				st_next.apb_st = cbrs_pkg::CBRS_IDLE;
				st_next.pready = 1'b0;
			end
		endcase
		if (apb_wr) begin
			for (int i = 0; i < cbrs_pkg::GP_N; i++) begin
				if (paddr == cbrs_pkg::A_GP + 8'(cbrs_pkg::STRIDE * i)) begin
					st_next.gp[i] = wv;
				end
			end
			for (int i = 0; i < cbrs_pkg::SEG_N; i++) begin
				if (paddr == cbrs_pkg::A_SEG + 8'(cbrs_pkg::STRIDE * i)) begin
					st_next.seg[i] = wv;
				end
				if (paddr == cbrs_pkg::A_SBASE + 8'(cbrs_pkg::STRIDE * i)) begin
					st_next.sbase[i] = pwdata[23:0];
				end
				if (paddr == cbrs_pkg::A_SLIM + 8'(cbrs_pkg::STRIDE * i)) begin
					st_next.slim[i] = wv;
				end
			end
			if (paddr == cbrs_pkg::A_IP) begin
				st_next.ip = wv;
			end
			if (paddr == cbrs_pkg::A_FLAGS) begin
				st_next.flags = wv & cbrs_pkg::FLAGS_MASK;
			end
			if (paddr == cbrs_pkg::A_MSW) begin
				st_next.msw = wv & cbrs_pkg::MSW_MASK;
			end
		end
		if (ip_adv) begin
			st_next.ip = st_reg.ip + {12'h000, ip_len};
		end
		if (res_valid) begin
			st_next.flags[cbrs_pkg::carry_flag_bit] = res_carry;
			st_next.flags[cbrs_pkg::parity_flag_bit] = ~^res_value[7:0];
			st_next.flags[cbrs_pkg::aux_flag_bit] = res_aux;
			st_next.flags[cbrs_pkg::zero_flag_bit] =
				res_byte ? (res_value[7:0] == 8'h00) : (res_value == 16'h0000);
			st_next.flags[cbrs_pkg::sign_flag_bit] = res_byte ? res_value[7] : res_value[15];
			st_next.flags[cbrs_pkg::overflow_flag_bit] = res_ovf;
		end
		if (str_step) begin
			if (st_reg.flags[cbrs_pkg::direction_flag_bit]) begin
				st_next.gp[cbrs_pkg::gp_src_idx] = st_reg.gp[cbrs_pkg::gp_src_idx] - delta;
				st_next.gp[cbrs_pkg::gp_dst_idx] = st_reg.gp[cbrs_pkg::gp_dst_idx] - delta;
			end else begin
				st_next.gp[cbrs_pkg::gp_src_idx] = st_reg.gp[cbrs_pkg::gp_src_idx] + delta;
				st_next.gp[cbrs_pkg::gp_dst_idx] = st_reg.gp[cbrs_pkg::gp_dst_idx] + delta;
			end
		end
		// The core writes after the bus, so it overrides a bus write in the same cycle.
		if (core_we) begin
			if (core_wsel < cbrs_pkg::SEL_SEG) begin
				if (core_wsel < 4'(cbrs_pkg::SPLIT_N) && core_wbyte == cbrs_pkg::WB_LO) begin
					st_next.gp[core_wsel[2:0]][7:0] = core_wdata[7:0];
				end else if (core_wsel < 4'(cbrs_pkg::SPLIT_N) &&
					core_wbyte == cbrs_pkg::WB_HI) begin
					st_next.gp[core_wsel[2:0]][15:8] = core_wdata[7:0];
				end else begin
					st_next.gp[core_wsel[2:0]] = core_wdata;
				end
			end else if (core_wsel < cbrs_pkg::SEL_IP) begin
				st_next.seg[core_wsel[1:0]] = core_wdata;
			end else if (core_wsel == cbrs_pkg::SEL_IP) begin
				st_next.ip = core_wdata;
			end else if (core_wsel == cbrs_pkg::SEL_FLAGS) begin
				st_next.flags = core_wdata & cbrs_pkg::FLAGS_MASK;
			end else if (core_wsel == cbrs_pkg::SEL_MSW) begin
				st_next.msw = core_wdata & cbrs_pkg::MSW_MASK;
			end
		end
		if (instr_done && st_reg.flags[cbrs_pkg::single_step_flag_bit]) begin
			st_next.step_irq = 1'b1;
			st_next.flags[cbrs_pkg::single_step_flag_bit] = 1'b0;
		end
		if (core_rsel < cbrs_pkg::SEL_SEG) begin
			st_next.core_rdata = st_reg.gp[core_rsel[2:0]];
		end else if (core_rsel < cbrs_pkg::SEL_IP) begin
			st_next.core_rdata = st_reg.seg[core_rsel[1:0]];
		end else if (core_rsel == cbrs_pkg::SEL_IP) begin
			st_next.core_rdata = st_reg.ip;
		end else if (core_rsel == cbrs_pkg::SEL_FLAGS) begin
			st_next.core_rdata = st_reg.flags;
		end else begin
			st_next.core_rdata = st_reg.msw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.slim <= {cbrs_pkg::SEG_N{cbrs_pkg::SLIM_RST}};
			st_reg.sbase <= {cbrs_pkg::SEG_N{cbrs_pkg::SBASE_RST}};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign agu_bus.req      = ag_req;
	assign agu_bus.rm       = ag_rm;
	assign agu_bus.disp     = ag_disp;
	assign agu_bus.base_b   = st_reg.gp[cbrs_pkg::gp_word_b];
	assign agu_bus.base_bp  = st_reg.gp[cbrs_pkg::gp_base_ptr];
	assign agu_bus.idx_si   = st_reg.gp[cbrs_pkg::gp_src_idx];
	assign agu_bus.idx_di   = st_reg.gp[cbrs_pkg::gp_dst_idx];
	assign agu_bus.seg_val  = st_reg.seg[ag_seg];
	assign agu_bus.seg_base = st_reg.sbase[ag_seg];
	assign agu_bus.seg_lim  = st_reg.slim[ag_seg];
	// one register set, mode only steers translation.
	assign agu_bus.pmode    = st_reg.msw[cbrs_pkg::msw_prot_bit];
	assign agu_bus.cpl      = st_reg.seg[cbrs_pkg::seg_code][1:0];

	cbrs_agu u_agu (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.bus     (agu_bus.agu)
	);

	assign pready     = st_reg.pready;
	assign prdata     = st_reg.prdata;
	assign pslverr    = st_reg.pslverr;
	assign core_rdata = st_reg.core_rdata;
	assign prot_mode  = st_reg.msw[cbrs_pkg::msw_prot_bit];
	assign step_irq   = st_reg.step_irq;
	assign int_enable = st_reg.flags[cbrs_pkg::int_enable_bit];
	assign str_down   = st_reg.flags[cbrs_pkg::direction_flag_bit];
	assign ip_value   = st_reg.ip;
	assign phys_addr  = agu_bus.phys;
	assign addr_valid = agu_bus.valid;
	assign addr_fault = agu_bus.fault;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_step_trap;
		ce && instr_done && st_reg.flags[cbrs_pkg::single_step_flag_bit]
			|=> step_irq && !st_reg.flags[cbrs_pkg::single_step_flag_bit];
	endproperty
	a_step_trap: assert property (p_step_trap) else $error("step trap missed");
	property p_flag_res;
		ce && res_valid && !core_we && !st_reg.pready
			|=> st_reg.flags[cbrs_pkg::carry_flag_bit] == $past(res_carry) &&
			st_reg.flags[cbrs_pkg::parity_flag_bit] == ~^$past(res_value[7:0]);
	endproperty
	a_flag_res: assert property (p_flag_res) else $error("carry or parity wrong");
	property p_byte_half;
		ce && core_we && core_wbyte == cbrs_pkg::WB_LO && core_wsel == 4'h0
			&& !st_reg.pready |=> $stable(st_reg.gp[cbrs_pkg::gp_word_a][15:8]);
	endproperty
	a_byte_half: assert property (p_byte_half) else $error("high byte disturbed");
	property p_str_up;
		ce && str_step && !str_down && !core_we && !st_reg.pready
			|=> st_reg.gp[cbrs_pkg::gp_src_idx] ==
			$past(st_reg.gp[cbrs_pkg::gp_src_idx]) +
			($past(str_word) ? cbrs_pkg::STEP_WORD : cbrs_pkg::STEP_BYTE);
	endproperty
	a_str_up: assert property (p_str_up) else $error("index not incremented");
	property p_flag_rsvd;
		(st_reg.flags & ~cbrs_pkg::FLAGS_MASK) == 16'h0000;
	endproperty
	a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bit set");
	property p_ip_adv;
		ce && ip_adv && !core_we && !st_reg.pready |=> ip_value == $past(ip_value) + $past(ip_len);
	endproperty
	a_ip_adv: assert property (p_ip_adv) else $error("ip not advanced");
	property p_apb_ack;
		ce && psel && penable && !pready |=> pready ##1 (!ce || !pready);
	endproperty
	a_apb_ack: assert property (p_apb_ack) else $error("apb ack not one cycle");
	property p_mode_addr;
		ce && ag_req && !prot_mode |=> addr_valid && !addr_fault;
	endproperty
	a_mode_addr: assert property (p_mode_addr) else $error("real mode fault");
	property p_cv_step;
		step_irq;
	endproperty
	c_cv_step: cover property (p_cv_step);
	property p_cv_prot;
		prot_mode && addr_valid && !addr_fault;
	endproperty
	c_cv_prot: cover property (p_cv_prot);
endmodule : cbrs_regfile

// *** verilog/cbrs_pkg.sv ***
// Shared constants and types of the base register set.
package cbrs_pkg;
	localparam int GP_N    = 8;
	localparam int SEG_N   = 4;
	localparam int SPLIT_N = 4;
	localparam int PHYS_W  = 24;
	localparam int REAL_W  = 20;
	localparam int VIRT_W  = 30;
	localparam int SEG_SH  = 4;
	localparam int gp_word_a    = 0;
	localparam int gp_word_c    = 1;
	localparam int gp_word_d    = 2;
	localparam int gp_word_b    = 3;
	localparam int gp_stack_ptr = 4;
	localparam int gp_base_ptr  = 5;
	localparam int gp_src_idx   = 6;
	localparam int gp_dst_idx   = 7;
	localparam int seg_code     = 1;
	localparam int carry_flag_bit       = 0;
	localparam int parity_flag_bit      = 2;
	localparam int aux_flag_bit         = 4;
	localparam int zero_flag_bit        = 6;
	localparam int sign_flag_bit        = 7;
	localparam int single_step_flag_bit = 8;
	localparam int int_enable_bit       = 9;
	localparam int direction_flag_bit   = 10;
	localparam int overflow_flag_bit    = 11;
	localparam int msw_prot_bit         = 0;
	localparam logic [15:0] FLAGS_MASK = 16'h0fd5;
	localparam logic [15:0] MSW_MASK   = 16'h0001;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam logic [15:0] SLIM_RST   = 16'hffff;
	localparam logic [23:0] SBASE_RST  = 24'h00_0000;
	localparam logic [15:0] STEP_BYTE  = 16'h0001;
	localparam logic [15:0] STEP_WORD  = 16'h0002;
	localparam logic [7:0] A_GP    = 8'h00;
	localparam logic [7:0] A_SEG   = 8'h20;
	localparam logic [7:0] A_IP    = 8'h30;
	localparam logic [7:0] A_FLAGS = 8'h34;
	localparam logic [7:0] A_MSW   = 8'h38;
	localparam logic [7:0] A_SBASE = 8'h40;
	localparam logic [7:0] A_SLIM  = 8'h50;
	localparam int         STRIDE  = 4;
	localparam logic [3:0] SEL_SEG   = 4'h8;
	localparam logic [3:0] SEL_IP    = 4'hc;
	localparam logic [3:0] SEL_FLAGS = 4'hd;
	localparam logic [3:0] SEL_MSW   = 4'he;
	localparam logic [1:0] WB_WORD = 2'b00;
	localparam logic [1:0] WB_LO   = 2'b01;
	localparam logic [1:0] WB_HI   = 2'b10;
	localparam logic [2:0] RM_B_SI  = 3'b000;
	localparam logic [2:0] RM_B_DI  = 3'b001;
	localparam logic [2:0] RM_BP_SI = 3'b010;
	localparam logic [2:0] RM_BP_DI = 3'b011;
	localparam logic [2:0] RM_SI    = 3'b100;
	localparam logic [2:0] RM_DI    = 3'b101;
	localparam logic [2:0] RM_BP    = 3'b110;
	typedef enum logic [0:0] {
		CBRS_IDLE = 1'b0,
		CBRS_ACK  = 1'b1
	} cbrs_apb_st_t;
endpackage : cbrs_pkg

// *** verilog/cbrs_agu_if.sv ***
// Link between the register set and its address generator.
`timescale 1ns/1ps
interface cbrs_agu_if;
	logic        req;
	logic [2:0]  rm;
	logic [15:0] disp;
	logic [15:0] base_b;
	logic [15:0] base_bp;
	logic [15:0] idx_si;
	logic [15:0] idx_di;
	logic [15:0] seg_val;
	logic [23:0] seg_base;
	logic [15:0] seg_lim;
	logic        pmode;
	logic [1:0]  cpl;
	logic [23:0] phys;
	logic        valid;
	logic        fault;
	modport regs (output req, rm, disp, base_b, base_bp, idx_si, idx_di, seg_val,
		seg_base, seg_lim, pmode, cpl, input phys, valid, fault);
	modport agu (input req, rm, disp, base_b, base_bp, idx_si, idx_di, seg_val,
		seg_base, seg_lim, pmode, cpl, output phys, valid, fault);
endinterface : cbrs_agu_if

// *** verilog/cbrs_agu.sv ***
// Operand address generator with real and protected translation.
`timescale 1ns/1ps
module cbrs_agu (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	cbrs_agu_if.agu  bus
);
	typedef struct packed {
		logic [23:0] phys;
		logic        valid;
		logic        fault;
	} cbrs_agu_st_t;
	cbrs_agu_st_t st_reg;
	cbrs_agu_st_t st_next;
	logic [15:0]  off;

	always_comb begin
		st_next = st_reg;
		off = 16'h0000;
		case (bus.rm)
			cbrs_pkg::RM_B_SI:  off = bus.base_b + bus.idx_si;
			cbrs_pkg::RM_B_DI:  off = bus.base_b + bus.idx_di;
			cbrs_pkg::RM_BP_SI: off = bus.base_bp + bus.idx_si;
			cbrs_pkg::RM_BP_DI: off = bus.base_bp + bus.idx_di;
			cbrs_pkg::RM_SI:    off = bus.idx_si;
			cbrs_pkg::RM_DI:    off = bus.idx_di;
			cbrs_pkg::RM_BP:    off = bus.base_bp;
			default:            off = bus.base_b;
		endcase
		off = off + bus.disp;
		st_next.valid = bus.req;
		if (bus.req) begin
			if (bus.pmode) begin
				st_next.phys = bus.seg_base + {8'h00, off};
				st_next.fault = (off > bus.seg_lim) || (bus.seg_val[1:0] < bus.cpl);
			end else begin
				st_next.phys = {4'h0, {bus.seg_val, 4'h0} + {4'h0, off}};
				st_next.fault = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign bus.phys  = st_reg.phys;
	assign bus.valid = st_reg.valid;
	assign bus.fault = st_reg.fault;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_real_1m;
		ce && bus.req && !bus.pmode |=> bus.valid && !bus.fault && bus.phys[23:20] == 4'h0;
	endproperty
	a_real_1m: assert property (p_real_1m) else $error("real address above 1M");
	property p_limit_fault;
		ce && bus.req && bus.pmode && (off > bus.seg_lim) |=> bus.valid && bus.fault;
	endproperty
	a_limit_fault: assert property (p_limit_fault) else $error("limit not faulted");
	property p_cv_fault;
		bus.valid && bus.fault;
	endproperty
	c_cv_fault: cover property (p_cv_fault);
endmodule : cbrs_agu

// *** verification/cbrs_core_model.sv ***
// Core-side stand-in that drives the execution inputs of the register set.
`timescale 1ns/1ps
module cbrs_core_model (
	input  wire logic        pclk,
	output logic             core_we,
	output logic [3:0]       core_wsel,
	output logic [1:0]       core_wbyte,
	output logic [15:0]      core_wdata,
	output logic [3:0]       core_rsel,
	input  wire logic [15:0] core_rdata,
	output logic             res_valid,
	output logic [15:0]      res_value,
	output logic             res_byte,
	output logic             res_carry,
	output logic             res_aux,
	output logic             res_ovf,
	output logic             instr_done,
	output logic             ip_adv,
	output logic [3:0]       ip_len,
	output logic             str_step,
	output logic             str_word,
	output logic             ag_req,
	output logic [2:0]       ag_rm,
	output logic [15:0]      ag_disp,
	output logic [1:0]       ag_seg
);
	initial begin
		{core_we, core_wsel, core_wbyte, core_wdata, core_rsel} = '0;
		{res_valid, res_value, res_byte, res_carry, res_aux, res_ovf} = '0;
		{instr_done, ip_adv, ip_len, str_step, str_word} = '0;
		{ag_req, ag_rm, ag_disp, ag_seg} = '0;
	end
	// Every write or fire request is a one-cycle pulse, dropped at the edge that takes it; the read select stays set.
	task automatic wr(input logic [3:0] s, input logic [1:0] b, input logic [15:0] d);
		@(posedge pclk);
		core_we    <= 1'b1;
		core_wsel  <= s;
		core_wbyte <= b;
		core_wdata <= d;
		@(posedge pclk);
		core_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] s, output logic [15:0] d);
		@(posedge pclk);
		core_rsel <= s;
		@(posedge pclk);
		#1;
		d = core_rdata;
	endtask : rd
	// Kinds: 0 result, 1 instruction done, 2 ip advance, 3 string step, 4 address.
	task automatic fire(input int k, input logic [15:0] v, input logic [4:0] x);
		@(posedge pclk);
		res_value <= v;
		{res_ovf, res_aux, res_carry} <= x[2:0];
		ip_len    <= x[3:0];
		str_word  <= x[0];
		ag_disp   <= v;
		ag_rm     <= x[2:0];
		ag_seg    <= x[4:3];
		{ag_req, str_step, ip_adv, instr_done, res_valid} <= 5'(1 << k);
		@(posedge pclk);
		{ag_req, str_step, ip_adv, instr_done, res_valid} <= 5'h00;
	endtask : fire
endmodule : cbrs_core_model

// *** verification/test_cpu_base_register_set.sv ***
// Self-checking bench of the base register set over APB and the core port.
`timescale 1ns/1ps
module test_cpu_base_register_set;
	logic        pclk = 1'b0;
	logic        presetn, ce, psel, penable, pwrite, pready, pslverr, re, seen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        core_we, res_valid, res_byte, res_carry, res_aux, res_ovf;
	logic        instr_done, ip_adv, str_step, str_word, ag_req;
	logic [3:0]  core_wsel, core_rsel, ip_len;
	logic [1:0]  core_wbyte, ag_seg;
	logic [15:0] core_wdata, core_rdata, res_value, ag_disp, ip_value, cd, off;
	logic [2:0]  ag_rm;
	logic        prot_mode, step_irq, int_enable, str_down, addr_valid, addr_fault;
	logic [23:0] phys_addr;
	logic [15:0] offt [8] = '{16'h0033, 16'h0017, 16'h0123, 16'h0107,
		16'h0023, 16'h0007, 16'h0103, 16'h0013};
	int          num_errors = 0;
	int          n_compared = 0;
	always #5 pclk = ~pclk;
	cbrs_regfile u_cbrs_regfile (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .core_we, .core_wsel, .core_wbyte, .core_wdata,
		.core_rsel, .core_rdata, .res_valid, .res_value, .res_byte, .res_carry, .res_aux,
		.res_ovf, .instr_done, .ip_adv, .ip_len, .str_step, .str_word, .ag_req, .ag_rm,
		.ag_disp, .ag_seg, .prot_mode, .step_irq, .int_enable, .str_down, .ip_value,
		.phys_addr, .addr_valid, .addr_fault);
	cbrs_core_model u_cbrs_core_model (.pclk, .core_we, .core_wsel, .core_wbyte,
		.core_wdata, .core_rsel, .core_rdata, .res_valid, .res_value, .res_byte, .res_carry,
		.res_aux, .res_ovf, .instr_done, .ip_adv, .ip_len, .str_step, .str_word, .ag_req,
		.ag_rm, .ag_disp, .ag_seg);
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// The request stands until pready is sampled high; a stuck slave ends the run.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		re = pslverr;
		{psel, penable} <= 2'b00;
		if (n == 20) begin
			num_errors++;
			finish_test();
		end
	endtask : apb
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		check(nm, rv, e);
	endtask : rd_chk
	task automatic wait_hi(ref logic s);
		seen = 1'b0;
		for (int n = 0; n < 4 && !seen; n++) begin
			#1;
			seen = (s === 1'b1);
			if (!seen) @(posedge pclk);
		end
	endtask : wait_hi
	initial begin
		{presetn, ce, psel, penable, pwrite, paddr, pwdata} = {2'b01, 43'h0};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 15; i++) rd_chk("reg reset", 8'(4 * i), 32'h0000_0000);
		for (int j = 0; j < 4; j++) rd_chk("limit reset", 8'(8'h50 + 4 * j), 32'h0000_ffff);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 8'(4 * i), 32'ha5a5_0000 | 32'(16'h1357 + 16'(i) * 16'h0101));
			rd_chk("gp word", 8'(4 * i), 32'(16'h1357 + 16'(i) * 16'h0101));
		end
		apb(1'b1, 8'h60, 32'h0000_1111);
		check("unmapped err", 32'(re), 32'h0000_0001);
		apb(1'b0, 8'h60, 32'h0000_0000);
		check("unmapped data", rv, 32'h0000_0000);
		check("unmapped rd err", 32'(re), 32'h0000_0001);
		$display("test word access done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'(4 * i), 32'h0000_1234);
			u_cbrs_core_model.wr(4'(i), cbrs_pkg::WB_LO, 16'h00ab);
			u_cbrs_core_model.rd(4'(i), cd);
			check("low byte", 32'(cd), 32'h0000_12ab);
			u_cbrs_core_model.wr(4'(i), cbrs_pkg::WB_HI, 16'h00cd);
			u_cbrs_core_model.rd(4'(i), cd);
			check("high byte", 32'(cd), 32'h0000_cdab);
		end
		$display("test byte halves done");
		apb(1'b1, cbrs_pkg::A_FLAGS, 32'h0000_ffff);
		rd_chk("flags mask", cbrs_pkg::A_FLAGS, 32'h0000_0fd5);
		check("int enable", 32'(int_enable), 32'h0000_0001);
		apb(1'b1, cbrs_pkg::A_FLAGS, 32'h0000_0400);
		// Zero result with carry and overflow, then odd low byte with sign and aux.
		u_cbrs_core_model.fire(0, 16'h0000, 5'h05);
		rd_chk("flags zero", cbrs_pkg::A_FLAGS, 32'h0000_0c45);
		u_cbrs_core_model.fire(0, 16'h8001, 5'h02);
		rd_chk("flags sign", cbrs_pkg::A_FLAGS, 32'h0000_0490);
		u_cbrs_core_model.fire(0, 16'h0103, 5'h00);
		rd_chk("flags parity", cbrs_pkg::A_FLAGS, 32'h0000_0404);
		$display("test result flags done");
		apb(1'b1, cbrs_pkg::A_FLAGS, 32'h0000_0100);
		u_cbrs_core_model.fire(1, 16'h0000, 5'h00);
		wait_hi(step_irq);
		check("step irq", 32'(seen), 32'h0000_0001);
		rd_chk("step clear", cbrs_pkg::A_FLAGS, 32'h0000_0000);
		u_cbrs_core_model.fire(1, 16'h0000, 5'h00);
		wait_hi(step_irq);
		check("no step irq", 32'(seen), 32'h0000_0000);
		apb(1'b1, cbrs_pkg::A_IP, 32'h0000_00fe);
		u_cbrs_core_model.fire(2, 16'h0000, 5'h03);
		#1;
		check("ip advance", 32'(ip_value), 32'h0000_0101);
		// A low clock enable must swallow an advance pulse entirely.
		@(posedge pclk);
		ce <= 1'b0;
		u_cbrs_core_model.fire(2, 16'h0000, 5'h03);
		#1;
		check("ce freeze", 32'(ip_value), 32'h0000_0101);
		@(posedge pclk);
		ce <= 1'b1;
		$display("test control done");
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, cbrs_pkg::A_FLAGS, d ? 32'h0000_0400 : 32'h0000_0000);
			apb(1'b1, 8'h18, 32'h0000_0010);
			apb(1'b1, 8'h1c, 32'h0000_0020);
			u_cbrs_core_model.fire(3, 16'h0000, 5'h00);
			u_cbrs_core_model.fire(3, 16'h0000, 5'h01);
			check("str down", 32'(str_down), 32'(d));
			rd_chk("src step", 8'h18, d ? 32'h0000_000d : 32'h0000_0013);
			rd_chk("dst step", 8'h1c, d ? 32'h0000_001d : 32'h0000_0023);
		end
		$display("test string step done");
		apb(1'b1, 8'h0c, 32'h0000_0010);
		apb(1'b1, 8'h14, 32'h0000_0100);
		apb(1'b1, 8'h18, 32'h0000_0020);
		apb(1'b1, 8'h1c, 32'h0000_0004);
		apb(1'b1, 8'h2c, 32'h0000_1000);
		apb(1'b1, 8'h4c, 32'h0012_3400);
		apb(1'b1, 8'h5c, 32'h0000_00ff);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, cbrs_pkg::A_MSW, 32'(m));
			#1;
			check("mode", 32'(prot_mode), 32'(m));
			for (int r = 0; r < 8; r++) begin
				u_cbrs_core_model.fire(4, 16'h0003, {2'd3, 3'(r)});
				wait_hi(addr_valid);
				if (!seen) begin
					num_errors++;
					finish_test();
				end
				off = offt[r];
				check("fault", 32'(addr_fault), 32'(m == 1 && off > 16'h00ff));
				if (m == 0) check("real addr", 32'(phys_addr), 32'h0001_0000 + 32'(off));
				if (m == 1 && off <= 16'h00ff) check("prot addr", 32'(phys_addr),
					32'h0012_3400 + 32'(off));
			end
		end
		apb(1'b1, 8'h24, 32'h0000_0002);
		u_cbrs_core_model.fire(4, 16'h0003, 5'h1f);
		wait_hi(addr_valid);
		check("priv fault", 32'(addr_fault), 32'h0000_0001);
		$display("test address done");
		u_cbrs_core_model.wr(4'hb, cbrs_pkg::WB_WORD, 16'h2000);
		u_cbrs_core_model.rd(4'hb, cd);
		check("seg load", 32'(cd), 32'h0000_2000);
		u_cbrs_core_model.wr(4'h4, cbrs_pkg::WB_HI, 16'h5678);
		u_cbrs_core_model.rd(4'h4, cd);
		check("unsplit word", 32'(cd), 32'h0000_5678);
		u_cbrs_core_model.wr(4'hc, cbrs_pkg::WB_WORD, 16'h0abc);
		u_cbrs_core_model.rd(4'hc, cd);
		check("core ip", 32'(cd), 32'h0000_0abc);
		u_cbrs_core_model.wr(4'hd, cbrs_pkg::WB_WORD, 16'hffff);
		u_cbrs_core_model.rd(4'hd, cd);
		check("core flags", 32'(cd), 32'h0000_0fd5);
		u_cbrs_core_model.wr(4'he, cbrs_pkg::WB_WORD, 16'h0000);
		u_cbrs_core_model.rd(4'he, cd);
		check("core mode", 32'(prot_mode), 32'h0000_0000);
		$display("test core port done");
		finish_test();
	end
endmodule : test_cpu_base_register_set
